// ### src/sira_pkg.sv
// Package of constants for the sensor register access I2C target port
`default_nettype none
package sira_pkg;
   // Target addresses selected by the two address-select pins {hi,lo}
   localparam logic [6:0] ADDR_LL = 7'h1a;
   localparam logic [6:0] ADDR_LH = 7'h10;
   localparam logic [6:0] ADDR_HL = 7'h36;
   localparam logic [6:0] ADDR_HH = 7'h37;
   localparam logic       DIR_WRITE = 1'h0;     // Direction bit value for write
   localparam logic       DIR_READ  = 1'h1;     // Direction bit value for read
   localparam int         BYTE_BITS = 8;        // Bits per byte on the link
   localparam int         REG_AW    = 16;       // Register address width
   localparam logic [2:0] BIT_LAST  = 3'h7;     // Index of last bit in a byte
   localparam logic [2:0] BIT_FIRST = 3'h0;     // Index of first bit in a byte
   localparam logic [15:0] INDEX_RESET = 16'h0000; // Register index after reset
   // Link phases
   typedef enum logic [2:0] {
      SIRA_IDLE, SIRA_DEVADDR, SIRA_ADDRH, SIRA_ADDRL, SIRA_WDATA, SIRA_RDATA, SIRA_ACK, SIRA_RACK
   } sira_phase_e;
endpackage
`default_nettype wire

// ### src/sira_sync.sv
// Two flip-flop synchroniser for the link pins
`default_nettype none
module sira_sync #(
   parameter int WIDTH = 2                       // Number of bits synchronised
) (
   input  wire logic             sys_clk_in,     // System clock
   input  wire logic             rst_in,         // Asynchronous reset, high
   input  wire logic [WIDTH-1:0] async_in,       // Asynchronous levels
   output logic      [WIDTH-1:0] sync_out        // Synchronised levels
);
   logic [WIDTH-1:0] meta;                       // First stage, read only by second
   // Reset high: idle bus level, so no false start appears after reset
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta     <= '1;
         sync_out <= '1;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

// ### src/sira_top.sv
// I2C target port giving a host write and read access to sensor registers
// Function
// - Bytes shift most significant bit first
// - Two select pins choose 7-bit target address
// - Direction bit: 0 write, 1 read
// - Frame-class writes apply at frame reflection
// - Immediate-class writes apply when transaction completes
// - 16-bit register address, then 8-bit data
// - Receiver acknowledges each byte, then releases
// - Sequential write acknowledges and advances index together
`default_nettype none
module sira_top #(
   parameter int AW = 16,                        // Register address width
   parameter int DW = 8                          // Register data width
) (
   input  wire logic          sys_clk_in,        // 20 MHz system clock
   input  wire logic          rst_in,            // Asynchronous reset, active high
   input  wire logic          scl_in,            // Link clock from host
   input  wire logic          sda_in,            // Link data level
   output logic               sda_out,           // Link data drive value, always low
   output logic               sda_oe_n_out,      // Low while pulling data line low
   input  wire logic          addr_select_pin_hi_in, // Upper address-select pin
   input  wire logic          addr_select_pin_lo_in, // Lower address-select pin
   input  wire logic          frame_reflect_in,  // Frame reflection point pulse
   input  wire logic          register_hold_function_in, // Hold frame-class updates
   input  wire logic          frame_class_in,    // Addressed register is frame class
   input  wire logic [DW-1:0] reg_rdata_in,      // Read data at reg_addr_out
   output logic      [AW-1:0] reg_addr_out,      // Current register index
   output logic      [AW-1:0] wr_addr_out,       // Write address
   output logic      [DW-1:0] wr_data_out,       // Write data
   output logic               wr_now_out,        // Immediate write pulse
   output logic               wr_frame_out,      // Frame-class write pulse
   output logic               busy_out           // Transaction in progress
);
   // Whole state in one packed struct
   typedef struct packed {
      sira_pkg::sira_phase_e phase;      // Link phase
      sira_pkg::sira_phase_e after_ack;  // Phase following an acknowledge slot
      logic            scl_d;            // Previous synced clock
      logic            sda_d;            // Previous synced data
      logic [2:0]      bitn;             // Bit index within byte
      logic [7:0]      sh;               // Shift register
      logic            rd;               // Current transaction is a read
      logic            pull;             // Pulling data line low
      logic [AW-1:0]   index;            // Register index
      logic [AW-1:0]   waddr;            // Latched write address
      logic [DW-1:0]   wdata;            // Latched write data
      logic            pend_now;         // Immediate write waiting for stop or repeated start
      logic            pend_frame;       // Frame write waiting for reflection
      logic            frame_sel;        // Pending write is frame class
      logic            wnow;             // Immediate write pulse
      logic            wframe;           // Frame write pulse
      logic            got;              // A bit has been taken since the start
      logic            host_ack;         // Host acknowledged the last read byte
   } sira_state_s;

   sira_state_s st;                      // Registered state
   sira_state_s next_st;                 // Next state
   logic [1:0]  pins;                    // Synced {scl, sda}
   logic        scl_s;                   // Synced clock
   logic        sda_s;                   // Synced data
   logic        scl_rise;                // Clock rising edge
   logic        scl_fall;                // Clock falling edge
   logic        start_c;                 // Start or repeated start
   logic        stop_c;                  // Stop
   logic [6:0]  my_addr;                 // Selected target address
   logic [1:0]  sel_s;                   // Synced select pins

   // Link pins pass two flip-flops before use; the clock is sampled, not used as a clock
   sira_sync #(.WIDTH(2)) u_sync_link (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .async_in   ({scl_in, sda_in}),
      .sync_out   (pins)
   );
   // Select pins are static straps but still synchronised
   sira_sync #(.WIDTH(2)) u_sync_sel (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .async_in   ({addr_select_pin_hi_in, addr_select_pin_lo_in}),
      .sync_out   (sel_s)
   );
   assign scl_s = pins[1];
   assign sda_s = pins[0];

   // Target address from the select pins
   always_comb begin
      case (sel_s)
         2'h0:    my_addr = sira_pkg::ADDR_LL;
         2'h1:    my_addr = sira_pkg::ADDR_LH;
         2'h2:    my_addr = sira_pkg::ADDR_HL;
         default: my_addr = sira_pkg::ADDR_HH;
      endcase
   end

   // Edge and bus condition detection on the synced samples
   assign scl_rise = scl_s & ~st.scl_d;
   assign scl_fall = ~scl_s & st.scl_d;
   assign start_c  = scl_s & st.scl_d & st.sda_d & ~sda_s;
   assign stop_c   = scl_s & st.scl_d & ~st.sda_d & sda_s;

   // Protocol engine: sample on clock rise, change data drive on clock fall
   always_comb begin
      next_st        = st;
      next_st.scl_d  = scl_s;
      next_st.sda_d  = sda_s;
      next_st.wnow   = 1'b0;
      next_st.wframe = 1'b0;
      // Frame-class write goes out at reflection unless hold keeps it back
      if (st.pend_frame && frame_reflect_in && !register_hold_function_in) begin
         next_st.pend_frame = 1'b0;
         next_st.wframe     = 1'b1;
      end
      if (stop_c || start_c) begin
         // Immediate write applied when the transaction completes
         if (st.pend_now) begin
            next_st.pend_now = 1'b0;
            next_st.wnow     = 1'b1;
         end
         next_st.pull  = 1'b0;
         next_st.bitn  = sira_pkg::BIT_FIRST;
         next_st.got   = 1'b0;
         next_st.phase = start_c ? sira_pkg::SIRA_DEVADDR : sira_pkg::SIRA_IDLE;
      end else if (scl_rise) begin
         case (st.phase)
            sira_pkg::SIRA_DEVADDR, sira_pkg::SIRA_ADDRH, sira_pkg::SIRA_ADDRL, sira_pkg::SIRA_WDATA: begin
               next_st.sh   = {st.sh[6:0], sda_s};
               next_st.got  = 1'b1;
               next_st.bitn = st.bitn + 3'h1;
            end
            sira_pkg::SIRA_RACK: begin
               // Index moves on either answer; the answer itself is acted on at the fall
               next_st.index    = st.index + 1'b1;
               next_st.host_ack = ~sda_s;
            end
            sira_pkg::SIRA_RDATA: begin
               next_st.bitn = st.bitn + 3'h1;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (st.phase)
            sira_pkg::SIRA_DEVADDR: begin
               if (st.bitn == sira_pkg::BIT_FIRST && st.got) begin // Skip the fall that follows the start
                  if (st.sh[7:1] == my_addr) begin
                     next_st.pull      = 1'b1;
                     next_st.rd        = (st.sh[0] == sira_pkg::DIR_READ);
                     next_st.after_ack = (st.sh[0] == sira_pkg::DIR_READ) ?
                                         sira_pkg::SIRA_RDATA : sira_pkg::SIRA_ADDRH;
                     next_st.phase     = sira_pkg::SIRA_ACK;
                  end else begin
                     next_st.phase = sira_pkg::SIRA_IDLE;
                  end
               end
            end
            sira_pkg::SIRA_ADDRH: begin
               if (st.bitn == sira_pkg::BIT_FIRST) begin
                  next_st.index[15:8] = st.sh;
                  next_st.pull        = 1'b1;
                  next_st.after_ack   = sira_pkg::SIRA_ADDRL;
                  next_st.phase       = sira_pkg::SIRA_ACK;
               end
            end
            sira_pkg::SIRA_ADDRL: begin
               if (st.bitn == sira_pkg::BIT_FIRST) begin
                  next_st.index[7:0] = st.sh;
                  next_st.pull       = 1'b1;
                  next_st.after_ack  = sira_pkg::SIRA_WDATA;
                  next_st.phase      = sira_pkg::SIRA_ACK;
               end
            end
            sira_pkg::SIRA_WDATA: begin
               if (st.bitn == sira_pkg::BIT_FIRST) begin
                  // Acknowledge and advance index together
                  next_st.waddr      = st.index;
                  next_st.wdata      = st.sh;
                  next_st.index      = st.index + 1'b1;
                  next_st.pull       = 1'b1;
                  next_st.after_ack  = sira_pkg::SIRA_WDATA;
                  next_st.phase      = sira_pkg::SIRA_ACK;
                  // One pending write slot: sequential bytes overwrite the held one
                  next_st.frame_sel  = frame_class_in;
                  next_st.pend_now   = ~frame_class_in;
                  next_st.pend_frame = frame_class_in;
               end
            end
            sira_pkg::SIRA_ACK: begin
               next_st.bitn  = sira_pkg::BIT_FIRST;
               next_st.phase = st.after_ack;
               if (st.after_ack == sira_pkg::SIRA_RDATA) begin
                  next_st.sh   = reg_rdata_in;
                  next_st.pull = ~reg_rdata_in[7];
               end else begin
                  next_st.pull = 1'b0;
               end
            end
            sira_pkg::SIRA_RDATA: begin
               if (st.bitn == sira_pkg::BIT_FIRST) begin
                  next_st.pull  = 1'b0;                         // Release for host acknowledge
                  next_st.phase = sira_pkg::SIRA_RACK;
               end else begin
                  next_st.pull = ~st.sh[sira_pkg::BIT_LAST - st.bitn];
               end
            end
            sira_pkg::SIRA_RACK: begin
               // Acknowledge fetches the byte at the advanced index, otherwise the read ends
               if (st.host_ack) begin
                  next_st.sh    = reg_rdata_in;
                  next_st.pull  = ~reg_rdata_in[7];
                  next_st.phase = sira_pkg::SIRA_RDATA;
               end else begin
                  next_st.phase = sira_pkg::SIRA_IDLE;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st       <= '0;
         st.scl_d <= 1'b1;
         st.sda_d <= 1'b1;
         st.index <= sira_pkg::INDEX_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Outputs
   assign sda_out      = 1'b0;
   assign sda_oe_n_out = ~st.pull;
   assign reg_addr_out = st.index;
   assign wr_addr_out  = st.waddr;
   assign wr_data_out  = st.wdata;
   assign wr_now_out   = st.wnow;
   assign wr_frame_out = st.wframe;
   assign busy_out     = (st.phase != sira_pkg::SIRA_IDLE);

   // Assertions
   property p_dev_ack;
      @(posedge sys_clk_in) disable iff (rst_in)
      (st.phase == sira_pkg::SIRA_ACK) |-> !sda_oe_n_out;
   endproperty
   a_dev_ack: assert property (p_dev_ack) else $error("ack slot not driven");
   property p_frame_wait;
      @(posedge sys_clk_in) disable iff (rst_in)
      wr_frame_out |-> $past(frame_reflect_in) && !$past(register_hold_function_in);
   endproperty
   a_frame_wait: assert property (p_frame_wait) else $error("frame write off reflection");
   property p_now_end;
      @(posedge sys_clk_in) disable iff (rst_in)
      wr_now_out |-> $past(stop_c) || $past(start_c);
   endproperty
   a_now_end: assert property (p_now_end) else $error("immediate write not at end");
   property p_idx_inc;
      @(posedge sys_clk_in) disable iff (rst_in)
      (st.phase == sira_pkg::SIRA_WDATA && next_st.phase == sira_pkg::SIRA_ACK)
      |=> reg_addr_out == $past(reg_addr_out) + 16'h0001;
   endproperty
   a_idx_inc: assert property (p_idx_inc) else $error("index not advanced");
   property p_addr_match;
      @(posedge sys_clk_in) disable iff (rst_in)
      (st.phase == sira_pkg::SIRA_DEVADDR && next_st.phase == sira_pkg::SIRA_ACK)
      |-> st.sh[7:1] == my_addr;
   endproperty
   a_addr_match: assert property (p_addr_match) else $error("wrong address acked");
   property p_rw_dir;
      @(posedge sys_clk_in) disable iff (rst_in)
      (st.phase == sira_pkg::SIRA_DEVADDR && next_st.phase == sira_pkg::SIRA_ACK)
      |=> st.rd == $past(st.sh[0]);
   endproperty
   a_rw_dir: assert property (p_rw_dir) else $error("direction misread");
   property p_addr_order;
      @(posedge sys_clk_in) disable iff (rst_in)
      (st.phase == sira_pkg::SIRA_ADDRH && next_st.phase == sira_pkg::SIRA_ACK)
      |=> reg_addr_out[15:8] == $past(st.sh);
   endproperty
   a_addr_order: assert property (p_addr_order) else $error("upper byte misplaced");
   property p_release;
      @(posedge sys_clk_in) disable iff (rst_in)
      (st.phase == sira_pkg::SIRA_RACK) |-> sda_oe_n_out;
   endproperty
   a_release: assert property (p_release) else $error("line not released");
   c_write: cover property (@(posedge sys_clk_in) disable iff (rst_in) wr_now_out);
   c_frame: cover property (@(posedge sys_clk_in) disable iff (rst_in) wr_frame_out);
   c_read:  cover property (@(posedge sys_clk_in) disable iff (rst_in) st.phase == sira_pkg::SIRA_RACK);
endmodule
`default_nettype wire

// ### test/sira_host_model.sv
// Behavioural I2C controller standing in for the host system
`default_nettype none
module sira_host_model (
   input  wire logic sda_in,    // Resolved data line level
   input  wire logic forbid_in, // High during the prohibited line period
   output logic      scl_out,   // Link clock, still and high outside frames
   output logic      sda_out    // Data drive, 1 releases the line
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int T_LOW  = 250;  // Long low phase leaves room for the sensor's late answer
   localparam int T_HIGH = 150;  // High phase, 400 ns period in all
   localparam int T_BUF  = 1300; // Bus free time after a stop
   // Idle bus: both lines released
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // Start or repeated start, held back while the line period is forbidden
   task automatic start();
      wait (forbid_in === 1'b0);
      #(T_LOW/4) sda_out = 1'b1;
      #(T_LOW*3/4) scl_out = 1'b1;
      #(T_HIGH) sda_out = 1'b0;
      #(T_HIGH) scl_out = 1'b0;
   endtask
   // Stop, then the free time before anything else
   task automatic stop();
      #(T_LOW/4) sda_out = 1'b0;
      #(T_LOW*3/4) scl_out = 1'b1;
      #(T_HIGH) sda_out = 1'b1;
      #(T_BUF);
   endtask
   // One clock: data changes only while the clock is low, sampled just before the fall
   task automatic bit_io(input logic b, output logic seen);
      #(T_LOW/4) sda_out = b;
      #(T_LOW*3/4) scl_out = 1'b1;
      #(T_HIGH) seen = sda_in;
      scl_out = 1'b0;
   endtask
   // Byte most significant bit first; b9 drives the ninth clock (1 releases for the sensor)
   task automatic xfer(input logic [7:0] tx, input logic b9, output logic [7:0] rx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], s);
         rx[i] = s;
      end
      bit_io(b9, s);
      ack = ~s;
   endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the sensor register access I2C target port
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk;                     // 20 MHz clock
   logic        rst;                         // Reset, active high
   logic        scl;                         // Link clock from host model
   logic        host_sda;                    // Host drive, 1 releases
   logic        sda_line;                    // Resolved open-drain line
   logic        sda_drv;                     // Device drive value
   logic        sda_oe_n;                    // Device pulls while low
   logic [1:0]  sel;                         // Address-select pins {hi,lo}
   logic        frame_pulse;                 // Frame reflection point
   logic        hold;                        // Register hold level
   logic        frame_class;                 // Addressed register is frame class
   logic        forbid;                      // Prohibited line period
   logic [15:0] reg_addr;                    // Device index
   logic [15:0] wr_addr;                     // Applied write address
   logic [7:0]  wr_data;                     // Applied write data
   logic [7:0]  rdata;                       // Read data for the index
   logic        wr_now;                      // Immediate write pulse
   logic        wr_frame;                    // Frame write pulse
   logic        busy;                        // Transaction in progress
   logic [7:0]  rx;                          // Byte seen by host
   logic        ack;                         // Ninth-bit answer
   int          err_total;                   // Mismatches
   int          n_checks;                    // Comparisons
   int          n_now;                       // Immediate pulses seen
   int          n_frame;                     // Frame pulses seen
   int          cycles;                      // Watchdog count
   // Pull-up wins unless somebody pulls low
   assign sda_line = host_sda & (sda_oe_n | sda_drv);
   // Register file stand-in, a pattern of the index
   assign rdata = reg_addr[7:0] ^ 8'h5a;
   sira_top i_dut (.sys_clk_in(sys_clk), .rst_in(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_drv),
      .sda_oe_n_out(sda_oe_n), .addr_select_pin_hi_in(sel[1]), .addr_select_pin_lo_in(sel[0]),
      .frame_reflect_in(frame_pulse), .register_hold_function_in(hold), .frame_class_in(frame_class),
      .reg_rdata_in(rdata), .reg_addr_out(reg_addr), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
      .wr_now_out(wr_now), .wr_frame_out(wr_frame), .busy_out(busy));
   sira_host_model i_host (.sda_in(sda_line), .forbid_in(forbid), .scl_out(scl), .sda_out(host_sda));
   always #25 sys_clk = ~sys_clk;
   // Pulse counters and watchdog; a hang counts as a mismatch
   always @(posedge sys_clk) begin
      cycles++;
      if (wr_now === 1'b1) n_now++;
      if (wr_frame === 1'b1) n_frame++;
      if (cycles == 30000) begin
         err_total++;
         finish_test();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // Host sends a byte and expects the sensor to acknowledge it
   task automatic wbyte(input logic [7:0] b);
      i_host.xfer(b, 1'b1, rx, ack);
      check(16'(ack), 16'h0001, "ack of written byte");
   endtask
   // Start, target address with write, index upper then lower byte
   task automatic setup(input logic [6:0] dev, input logic [15:0] ra);
      i_host.start();
      wbyte({dev, sira_pkg::DIR_WRITE});
      wbyte(ra[15:8]);
      wbyte(ra[7:0]);
   endtask
   task automatic pulse_frame();
      @(posedge sys_clk) #1 frame_pulse = 1'b1;
      @(posedge sys_clk) #1 frame_pulse = 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   // Immediate-class write applies only once the message is over
   task automatic t_single_write();
      int base;
      base = n_now;
      setup(sira_pkg::ADDR_LL, 16'h3000);
      check(16'(busy), 16'h0001, "busy mid message");
      wbyte(8'hc3);
      check(16'(n_now - base), 16'h0000, "write before stop");
      i_host.stop();
      check(16'(n_now - base), 16'h0001, "write after stop");
      check(wr_addr, 16'h3000, "write address");
      check(16'(wr_data), 16'h00c3, "write data");
      check(reg_addr, 16'h3001, "index after write");
      check(16'(busy), 16'h0000, "busy after stop");
   endtask
   // Each select setting answers to its own address and refuses the next setting's address
   task automatic t_select();
      logic [6:0] tab [4];
      tab = '{sira_pkg::ADDR_LL, sira_pkg::ADDR_LH, sira_pkg::ADDR_HL, sira_pkg::ADDR_HH};
      for (int k = 0; k < 4; k++) begin
         @(posedge sys_clk) #1 sel = 2'(k);
         repeat (4) @(posedge sys_clk);
         i_host.start();
         i_host.xfer({tab[(k + 1) % 4], sira_pkg::DIR_WRITE}, 1'b1, rx, ack);
         check(16'(ack), 16'h0000, "foreign address refused");
         i_host.stop();
         i_host.start();
         i_host.xfer({tab[k], sira_pkg::DIR_WRITE}, 1'b1, rx, ack);
         check(16'(ack), 16'h0001, "own address taken");
         i_host.stop();
      end
   endtask
   // Sequential frame-class write held back until an unheld reflection point
   task automatic t_frame_write();
      int bn;
      int bf;
      @(posedge sys_clk) #1 frame_class = 1'b1;
      hold = 1'b1;
      bn = n_now;
      bf = n_frame;
      setup(sira_pkg::ADDR_HH, 16'h3010);
      wbyte(8'h11);
      wbyte(8'h22);
      i_host.stop();
      check(reg_addr, 16'h3012, "index after two bytes");
      pulse_frame();
      check(16'(n_frame - bf), 16'h0000, "held frame write");
      @(posedge sys_clk) #1 hold = 1'b0;
      pulse_frame();
      check(16'(n_frame - bf), 16'h0001, "frame write applied");
      check(16'(n_now - bn), 16'h0000, "no immediate write");
      check(wr_addr, 16'h3011, "frame write address");
      check(16'(wr_data), 16'h0022, "frame write data");
      @(posedge sys_clk) #1 frame_class = 1'b0;
   endtask
   // Dummy write, repeated start, two reads, then a read from the current index
   task automatic t_random_read();
      setup(sira_pkg::ADDR_HH, 16'h30ab);
      i_host.start();
      wbyte({sira_pkg::ADDR_HH, sira_pkg::DIR_READ});
      i_host.xfer(8'hff, 1'b0, rx, ack);
      check(16'(rx), 16'(8'hab ^ 8'h5a), "first read byte");
      i_host.xfer(8'hff, 1'b1, rx, ack);
      check(16'(rx), 16'(8'hac ^ 8'h5a), "second read byte");
      i_host.stop();
      check(reg_addr, 16'h30ad, "index after reads");
      i_host.start();
      wbyte({sira_pkg::ADDR_HH, sira_pkg::DIR_READ});
      i_host.xfer(8'hff, 1'b1, rx, ack);
      check(16'(rx), 16'(8'had ^ 8'h5a), "current location read");
      i_host.stop();
   endtask
   // Host holds its start back through the prohibited line period
   task automatic t_forbid();
      @(posedge sys_clk) #1 forbid = 1'b1;
      fork
         i_host.start();
         begin
            repeat (40) @(posedge sys_clk);
            check(16'(busy), 16'h0000, "start inside forbidden period");
            #1 forbid = 1'b0;
         end
      join
      wbyte({sira_pkg::ADDR_HH, sira_pkg::DIR_WRITE});
      i_host.stop();
   endtask
   task automatic finish_test();
      if (err_total == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Reset for five cycles, then the scenarios in turn
   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      sel = 2'h0;
      frame_pulse = 1'b0;
      hold = 1'b0;
      frame_class = 1'b0;
      forbid = 1'b0;
      err_total = 0;
      n_checks = 0;
      n_now = 0;
      n_frame = 0;
      cycles = 0;
      repeat (5) @(posedge sys_clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge sys_clk);
      t_single_write();
      t_select();
      t_frame_write();
      t_random_read();
      t_forbid();
      finish_test();
   end
endmodule
`default_nettype wire
